// ===== src/rsd_core.sv
// receive data core: spi slave, byte fifo, sync pattern detector
// assumes demod bits and chip_mode come from mclk logic; spi pins async,
// sck high and low phases each last at least 3 mclk cycles
// Functional notes
// - slave only, spi mode 0, full duplex
// - address byte then one or more data bytes
// - burst: register address increments per byte
// - fifo address stays fixed within frame
// - sample mosi rising, drive miso falling
// - miso released while nss high
// - first byte: write bit, 7-bit address
// - data bytes shifted msb first
// - nss rise ends frame, next is address
// - write returns previous register contents
// - 66x8 fifo fed by bit shift register
// - has-data flag tracks fifo while nss high, held during frame
// - full flag high only when completely full
// - overrun drops byte; writing 1 clears flag and fifo
// - level flag trip set by threshold field
// - fifo cleared when entering receive or on overrun clear
// - enabled detector compares bits against pattern
// - first bit vs msb of first byte
// - match cleared leaving receive or emptied
// - pattern length one to eight bytes
// - zero to seven bit errors tolerated
`include "rsd_map.svh"

module rsd_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = `RSD_FIFO_DEPTH,
   parameter int unsigned CW = $clog2(DEPTH + 1)
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic clr,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [CW-1:0] count
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic push, pop;

   if (DEPTH < 2 || W < 1) begin : g_bad
      $error("rsd_fifo: unsupported depth or width");
   end

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : ptr_inc

   assign in_ready = (cnt_reg != CW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign count = cnt_reg;
   assign push = in_valid && in_ready;
   assign pop = out_ready && out_valid;

   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      cnt_next = cnt_reg;
      if (clr) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         cnt_next = '0;
      end else begin
         if (push) wr_ptr_next = ptr_inc(wr_ptr_reg);
         if (pop) rd_ptr_next = ptr_inc(rd_ptr_reg);
         if (push && !pop) cnt_next = CW'(cnt_reg + 1'b1);
         if (pop && !push) cnt_next = CW'(cnt_reg - 1'b1);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else if (ce) begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // storage carries no reset; pointers guard it
   always_ff @(posedge mclk) begin
      if (ce && push && !clr) mem[wr_ptr_reg] <= in_data;
   end
endmodule : rsd_fifo

module rsd_core #(
   parameter int unsigned DEPTH = `RSD_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire rsd_pkg::rsd_spi_in_s spi_in,
   output logic miso,
   output logic miso_oe,
   input wire rsd_pkg::rsd_demod_s demod,
   input wire rsd_pkg::rsd_mode_e chip_mode,
   output rsd_pkg::rsd_flags_s flags
);
   import rsd_pkg::*;
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 2 || DEPTH > 255) begin : g_bad
      $error("rsd_core: fifo depth out of range");
   end

   // pin synchronisers: stage 1 feeds stage 2 only
   logic [2:0] s1_reg, s2_reg, s3_reg;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_reg <= 3'h2;
         s2_reg <= 3'h2;
         s3_reg <= 3'h2;
      end else if (ce) begin
         s1_reg <= spi_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   logic sck_rise, sck_fall, nss_hi, mosi_s;
   assign sck_rise = s2_reg[2] && !s3_reg[2];
   assign sck_fall = !s2_reg[2] && s3_reg[2];
   assign nss_hi = s2_reg[1];
   assign mosi_s = s2_reg[0];

   // fifo
   logic fifo_clr, push_v_reg, push_v_next, fifo_ready, fifo_valid, pop;
   logic [7:0] push_d_reg, push_d_next, fifo_data;
   logic [CW-1:0] fifo_cnt;
   rsd_fifo #(.W(8), .DEPTH(DEPTH), .CW(CW)) u_fifo (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .clr(fifo_clr),
      .in_valid(push_v_reg),
      .in_ready(fifo_ready),
      .in_data(push_d_reg),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data),
      .count(fifo_cnt)
   );

   // configuration registers
   logic [7:0] pcfg_reg, pcfg_next;
   logic [7:0] pval_reg [`RSD_PAT_BYTES];
   logic [7:0] pval_next [`RSD_PAT_BYTES];
   logic [6:0] thr_reg, thr_next;
   logic wr_en, ovr_clr;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;

   // spi state
   rsd_spi_st_e st_reg, st_next;
   logic [2:0] bcnt_reg, bcnt_next;
   logic [7:0] rx_reg, rx_next, tx_reg, tx_next, rd_data;
   logic [6:0] addr_reg, addr_next;
   logic wnr_reg, wnr_next, reload_reg, reload_next;
   logic txf_reg, txf_next, miso_reg, miso_next, oe_reg, oe_next;
   logic byte_end;

   // detector and flags state
   rsd_mode_e mode_prev_reg;
   logic [63:0] hist_reg, hist_next;
   logic [6:0] hcnt_reg, hcnt_next;
   logic [7:0] sr_reg, sr_next;
   logic [2:0] srcnt_reg, srcnt_next;
   logic match_reg, match_next, ovr_reg, ovr_next, valid_prev_reg;
   logic has_reg, has_next, full_reg, full_next, thr_f_reg, thr_f_next;
   logic enter_rx, leave_rx, hit;

   function automatic logic [6:0] popcnt(input logic [63:0] v);
      popcnt = '0;
      for (int i = 0; i < 64; i++) popcnt = 7'(popcnt + 7'(v[i]));
   endfunction : popcnt

   always_comb begin
      rd_data = 8'h00;
      unique case (addr_reg) inside
         `RSD_ADDR_FIFO: rd_data = fifo_valid ? fifo_data : 8'h00;
         `RSD_ADDR_PCFG: rd_data = pcfg_reg;
         [`RSD_ADDR_PVAL0:`RSD_ADDR_PVAL7]:
            rd_data = pval_reg[3'(addr_reg - `RSD_ADDR_PVAL0)];
         `RSD_ADDR_THR: rd_data = {1'b0, thr_reg};
         `RSD_ADDR_STAT: rd_data = {3'h0, flags};
         default: rd_data = 8'h00;
      endcase
   end

   assign byte_end = !nss_hi && sck_rise && (bcnt_reg == 3'h7);

   always_comb begin
      st_next = st_reg;
      bcnt_next = bcnt_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      addr_next = addr_reg;
      wnr_next = wnr_reg;
      reload_next = 1'b0;
      txf_next = txf_reg;
      miso_next = miso_reg;
      oe_next = 1'b0;
      wr_en = 1'b0;
      wr_addr = addr_reg;
      wr_data = {rx_reg[6:0], mosi_s};
      pop = 1'b0;
      if (nss_hi) begin
         st_next = RSD_SPI_ADDR;
         bcnt_next = 3'h0;
         tx_next = 8'h00;
         txf_next = 1'b0;
         miso_next = 1'b0;
      end else begin
         oe_next = 1'b1;
         if (reload_reg) begin
            // previous contents, loaded before the write to this address lands
            tx_next = rd_data;
            txf_next = (addr_reg == `RSD_ADDR_FIFO) && !wnr_reg && fifo_valid;
         end
         if (sck_rise) begin
            rx_next = {rx_reg[6:0], mosi_s};
            bcnt_next = 3'(bcnt_reg + 3'h1);
         end
         if (byte_end) begin
            reload_next = 1'b1;
            if (st_reg == RSD_SPI_ADDR) begin
               wnr_next = rx_reg[6];
               addr_next = {rx_reg[5:0], mosi_s};
               st_next = RSD_SPI_DATA;
            end else begin
               wr_en = wnr_reg;
               if (addr_reg != `RSD_ADDR_FIFO)
                  addr_next = addr_reg + 7'h01;
               else
                  pop = txf_reg;
            end
         end
         if (sck_fall) begin
            miso_next = tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_reg <= RSD_SPI_ADDR;
         bcnt_reg <= 3'h0;
         rx_reg <= 8'h00;
         tx_reg <= 8'h00;
         addr_reg <= 7'h00;
         wnr_reg <= 1'b0;
         reload_reg <= 1'b0;
         txf_reg <= 1'b0;
         miso_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
         bcnt_reg <= bcnt_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         addr_reg <= addr_next;
         wnr_reg <= wnr_next;
         reload_reg <= reload_next;
         txf_reg <= txf_next;
         miso_reg <= miso_next;
         oe_reg <= oe_next;
      end
   end
   assign miso = miso_reg;
   assign miso_oe = oe_reg;

   // register writes; the fifo address takes no write data
   assign ovr_clr = wr_en && (wr_addr == `RSD_ADDR_STAT) &&
                    wr_data[`RSD_STAT_OVR];
   always_comb begin
      pcfg_next = pcfg_reg;
      pval_next = pval_reg;
      thr_next = thr_reg;
      if (wr_en) begin
         unique case (wr_addr) inside
            `RSD_ADDR_PCFG: pcfg_next = wr_data;
            [`RSD_ADDR_PVAL0:`RSD_ADDR_PVAL7]:
               pval_next[3'(wr_addr - `RSD_ADDR_PVAL0)] = wr_data;
            `RSD_ADDR_THR: thr_next = wr_data[6:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pcfg_reg <= `RSD_PCFG_RST;
         pval_reg <= '{default: `RSD_PVAL_RST};
         thr_reg <= `RSD_THR_RST;
      end else if (ce) begin
         pcfg_reg <= pcfg_next;
         pval_reg <= pval_next;
         thr_reg <= thr_next;
      end
   end

   // pattern detector and receive shift register
   logic [3:0] plen;
   logic [6:0] pbits;
   logic [63:0] pflat, pmask, ptarget;
   assign plen = 4'(pcfg_reg[`RSD_PCFG_LEN_MSB:`RSD_PCFG_LEN_LSB]) + 4'h1;
   assign pbits = {plen, 3'h0};
   assign pflat = {pval_reg[0], pval_reg[1], pval_reg[2], pval_reg[3],
                   pval_reg[4], pval_reg[5], pval_reg[6], pval_reg[7]};
   // byte 0 msb lines up with the oldest compared bit
   assign ptarget = pflat >> (7'd64 - pbits);
   assign pmask = ~(64'hffff_ffff_ffff_ffff << pbits);
   assign enter_rx = (chip_mode == RSD_RX) && (mode_prev_reg != RSD_RX);
   assign leave_rx = (chip_mode != RSD_RX) && (mode_prev_reg == RSD_RX);
   assign fifo_clr = enter_rx || ovr_clr;

   always_comb begin
      hist_next = hist_reg;
      hcnt_next = hcnt_reg;
      sr_next = sr_reg;
      srcnt_next = srcnt_reg;
      push_v_next = 1'b0;
      push_d_next = push_d_reg;
      match_next = match_reg;
      ovr_next = ovr_reg;
      hit = 1'b0;
      if (leave_rx || (valid_prev_reg && !fifo_valid))
         match_next = 1'b0;
      if (ovr_clr) ovr_next = 1'b0;
      if (enter_rx) begin
         hcnt_next = 7'h00;
         srcnt_next = 3'h0;
      end
      if (demod.valid && chip_mode == RSD_RX) begin
         hist_next = {hist_reg[62:0], demod.data};
         if (hcnt_reg != 7'd64) hcnt_next = 7'(hcnt_reg + 7'h01);
         hit = pcfg_reg[`RSD_PCFG_EN] && (hcnt_next >= pbits) &&
               (popcnt((hist_next ^ ptarget) & pmask) <=
                7'(pcfg_reg[`RSD_PCFG_TOL_MSB:`RSD_PCFG_TOL_LSB]));
         if (pcfg_reg[`RSD_PCFG_EN] && !match_reg) begin
            srcnt_next = 3'h0;
            if (hit) match_next = 1'b1;
         end else begin
            sr_next = {sr_reg[6:0], demod.data};
            srcnt_next = 3'(srcnt_reg + 3'h1);
            if (srcnt_reg == 3'h7) begin
               push_v_next = 1'b1;
               push_d_next = {sr_reg[6:0], demod.data};
            end
         end
      end
      // a drop in the same cycle as the clear does not flag
      if (push_v_reg && !fifo_ready && !fifo_clr) ovr_next = 1'b1;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_prev_reg <= RSD_SLEEP;
         hist_reg <= '0;
         hcnt_reg <= 7'h00;
         sr_reg <= 8'h00;
         srcnt_reg <= 3'h0;
         push_v_reg <= 1'b0;
         push_d_reg <= 8'h00;
         match_reg <= 1'b0;
         ovr_reg <= 1'b0;
         valid_prev_reg <= 1'b0;
      end else if (ce) begin
         mode_prev_reg <= chip_mode;
         hist_reg <= hist_next;
         hcnt_reg <= hcnt_next;
         sr_reg <= sr_next;
         srcnt_reg <= srcnt_next;
         push_v_reg <= push_v_next;
         push_d_reg <= push_d_next;
         match_reg <= match_next;
         ovr_reg <= ovr_next;
         valid_prev_reg <= fifo_valid;
      end
   end

   // status flags; has-data frozen while a frame runs
   always_comb begin
      has_next = has_reg;
      if (nss_hi) has_next = fifo_valid;
      full_next = (fifo_cnt == CW'(DEPTH));
      thr_f_next = (fifo_cnt > CW'(thr_reg));
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         has_reg <= 1'b0;
         full_reg <= 1'b0;
         thr_f_reg <= 1'b0;
      end else if (ce) begin
         has_reg <= has_next;
         full_reg <= full_next;
         thr_f_reg <= thr_f_next;
      end
   end

   assign flags.buffer_has_data_flag = has_reg;
   assign flags.buffer_full_flag = full_reg;
   assign flags.buffer_threshold_flag = thr_f_reg;
   assign flags.buffer_overrun_flag = ovr_reg;
   assign flags.pattern_match_flag = match_reg;

   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);

   sequence s_byte_end;
      ce && byte_end && st_reg == RSD_SPI_DATA;
   endsequence
   sequence s_addr_byte;
      ce && byte_end && st_reg == RSD_SPI_ADDR;
   endsequence

   AST_OE_OFF: assert property (ce && nss_hi |=> !miso_oe)
      else $error("miso driven while nss high");
   // the frame-end reset of miso coincides with the release of the pin
   AST_MISO_FALL: assert property (!(ce && sck_fall) |=>
      $stable(miso) || !miso_oe)
      else $error("miso moved outside a falling sck edge");
   AST_ADDR_LATCH: assert property (s_addr_byte |=>
      st_reg == RSD_SPI_DATA && wnr_reg == $past(rx_reg[6]))
      else $error("address byte not decoded");
   AST_BURST_INC: assert property (s_byte_end ##0
      (addr_reg != `RSD_ADDR_FIFO) |=> addr_reg == $past(addr_reg) + 7'h01)
      else $error("burst address did not increment");
   AST_FIFO_HOLD: assert property (s_byte_end ##0
      (addr_reg == `RSD_ADDR_FIFO) |=> addr_reg == `RSD_ADDR_FIFO)
      else $error("fifo address moved");
   AST_PREV_DATA: assert property (ce && byte_end && !nss_hi ##1
      ce && reload_reg && !nss_hi |=> tx_reg == $past(rd_data))
      else $error("returned byte is not the prior contents");
   AST_FULL: assert property (ce |=>
      flags.buffer_full_flag == ($past(fifo_cnt) == CW'(DEPTH)))
      else $error("full flag wrong");
   AST_OVR: assert property (ce && push_v_reg && !fifo_ready && !fifo_clr
      |=> flags.buffer_overrun_flag)
      else $error("overrun not flagged");
   AST_THR: assert property (ce |=>
      flags.buffer_threshold_flag ==
      ($past(fifo_cnt) > CW'($past(thr_reg))))
      else $error("threshold flag wrong");
   AST_RX_CLR: assert property (ce && enter_rx |=> fifo_cnt == '0)
      else $error("fifo kept on entering receive");
   AST_EMPTY_POP: assert property (pop |-> fifo_valid)
      else $error("pop from empty fifo");
   AST_MATCH_CLR: assert property (ce && leave_rx |=> !match_reg)
      else $error("match kept after leaving receive");
endmodule : rsd_core

// ===== src/rsd_map.svh
// register map, field positions, reset values of the receive data core
// assumes inclusion by rsd_core.sv only; rsd_pkg.sv does not include it
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH
`define RSD_ADDR_FIFO 7'h00
`define RSD_ADDR_PCFG 7'h01
`define RSD_ADDR_PVAL0 7'h02
`define RSD_ADDR_PVAL7 7'h09
`define RSD_ADDR_THR 7'h0a
`define RSD_ADDR_STAT 7'h0b
`define RSD_PCFG_EN 7
`define RSD_PCFG_LEN_MSB 5
`define RSD_PCFG_LEN_LSB 3
`define RSD_PCFG_TOL_MSB 2
`define RSD_PCFG_TOL_LSB 0
`define RSD_STAT_HAS_DATA 0
`define RSD_STAT_FULL 1
`define RSD_STAT_THR 2
`define RSD_STAT_OVR 3
`define RSD_STAT_MATCH 4
`define RSD_PCFG_RST 8'h18
`define RSD_PVAL_RST 8'h01
`define RSD_THR_RST 7'h0f
`define RSD_FIFO_DEPTH 66
`define RSD_PAT_BYTES 8
`endif

// ===== src/rsd_pkg.sv
// types shared by the receive data core
// assumes no include file; uses no rsd_map.svh macros
package rsd_pkg;
   typedef enum logic [1:0] {RSD_SLEEP, RSD_STDBY, RSD_RX} rsd_mode_e;
   typedef enum logic {RSD_SPI_ADDR, RSD_SPI_DATA} rsd_spi_st_e;
   typedef struct packed {
      logic sck;
      logic nss_n;
      logic mosi;
   } rsd_spi_in_s;
   typedef struct packed {
      logic valid;
      logic data;
   } rsd_demod_s;
   typedef struct packed {
      logic pattern_match_flag;
      logic buffer_overrun_flag;
      logic buffer_threshold_flag;
      logic buffer_full_flag;
      logic buffer_has_data_flag;
   } rsd_flags_s;
endpackage : rsd_pkg

// ===== verif/rsd_core_tb.sv
// self-checking bench of the receive data core
// assumes rsd_pkg and rsd_spi_master compiled first; no checker file
module rsd_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rsd_pkg::*;
   logic mclk = 1'b0;
   logic nrst;
   logic ce;
   rsd_spi_in_s spi_in;
   logic miso;
   logic miso_oe;
   rsd_demod_s demod;
   rsd_mode_e chip_mode;
   rsd_flags_s flags;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] pcfg_t [5] = '{8'h88, 8'h89, 8'h88, 8'h88, 8'h80};
   logic [15:0] pat_t [5] = '{16'h2dd4, 16'h2dd5, 16'h2dd5, 16'hb42b,
      16'h002d};
   logic exp_t [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

   always #10 mclk = ~mclk;

   rsd_core #(.DEPTH(66)) dut (.mclk(mclk), .nrst(nrst), .ce(ce),
      .spi_in(spi_in), .miso(miso), .miso_oe(miso_oe), .demod(demod),
      .chip_mode(chip_mode), .flags(flags));

   rsd_spi_master m_spi (.mclk(mclk), .spi_in(spi_in), .miso(miso),
      .miso_oe(miso_oe));

   task automatic check(input string what, input logic [7:0] seen,
         input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic flg(input logic [7:0] exp);
      check("flags", {3'b000, flags}, exp);
   endtask : flg

   task automatic rd(input logic [6:0] a, input int n);
      m_spi.frame({1'b0, a}, n);
   endtask : rd

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      m_spi.wbuf[0] = d;
      m_spi.frame({1'b1, a}, 1);
   endtask : wr

   task automatic go(input rsd_mode_e md);
      @(negedge mclk);
      chip_mode = md;
      repeat (3) @(negedge mclk);
   endtask : go

   task automatic bits(input logic [63:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge mclk);
         demod = '{valid: 1'b1, data: v[i]};
         @(negedge mclk);
         demod.valid = 1'b0;
         demod.data = ~demod.data;
      end
      repeat (5) @(negedge mclk);
   endtask : bits

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #1_500_000;
      fail_count++;
      print_verdict();
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      chip_mode = RSD_STDBY;
      demod = '0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      repeat (4) @(negedge mclk);
      flg(8'h00);
      rd(7'h01, 10);
      check("pcfg", m_spi.rbuf[0], 8'h18);
      for (int i = 1; i < 9; i++) begin
         check("pval", m_spi.rbuf[i], 8'h01);
      end
      check("thr", m_spi.rbuf[9], 8'h0f);
      check("oe idle", {7'h00, miso_oe}, 8'h00);
      m_spi.wbuf[0] = 8'h2d;
      m_spi.wbuf[1] = 8'hd4;
      m_spi.frame(8'h82, 2);
      check("old pval", m_spi.rbuf[1], 8'h01);
      rd(7'h02, 2);
      check("pval1", m_spi.rbuf[0], 8'h2d);
      check("pval2", m_spi.rbuf[1], 8'hd4);
      wr(7'h0a, 8'h03);
      check("old thr", m_spi.rbuf[0], 8'h0f);
      rd(7'h0c, 1);
      check("unmapped", m_spi.rbuf[0], 8'h00);
      $display("test registers done");

      go(RSD_RX);
      bits(64'h11a2b3c4, 32);
      flg(8'h05);
      go(RSD_SLEEP);
      go(RSD_STDBY);
      go(RSD_SLEEP);
      go(RSD_STDBY);
      flg(8'h05);
      rd(7'h00, 3);
      check("fifo0", m_spi.rbuf[0], 8'h11);
      check("fifo1", m_spi.rbuf[1], 8'ha2);
      check("fifo2", m_spi.rbuf[2], 8'hb3);
      flg(8'h01);
      rd(7'h00, 1);
      check("fifo3", m_spi.rbuf[0], 8'hc4);
      flg(8'h00);
      rd(7'h00, 1);
      check("empty rd", m_spi.rbuf[0], 8'h00);
      go(RSD_RX);
      bits(64'h5a, 8);
      rd(7'h00, 1);
      check("after empty", m_spi.rbuf[0], 8'h5a);
      $display("test fifo done");

      for (int i = 0; i < 65; i++) begin
         bits(64'(i + 1), 8);
      end
      flg(8'h05);
      bits(64'h66, 8);
      flg(8'h07);
      bits(64'hee, 8);
      flg(8'h0f);
      wr(7'h0b, 8'h08);
      check("old stat", m_spi.rbuf[0], 8'h0f);
      flg(8'h00);
      $display("test overrun done");

      for (int i = 0; i < 5; i++) begin
         go(RSD_STDBY);
         wr(7'h01, pcfg_t[i]);
         go(RSD_RX);
         bits(64'(pat_t[i]), 16);
         flg({3'b000, exp_t[i], 4'h0});
         if (exp_t[i]) begin
            bits(64'h3c, 8);
            flg(8'h11);
            if (i == 0) begin
               rd(7'h00, 1);
               check("after sync", m_spi.rbuf[0], 8'h3c);
               flg(8'h00);
            end else begin
               go(RSD_STDBY);
               flg(8'h01);
            end
         end
      end
      $display("test pattern done");
      print_verdict();
   end
endmodule : rsd_core_tb

// ===== verif/rsd_spi_master.sv
// spi master model facing the receive data core: mode 0, msb first
// assumes a 50 MHz mclk; each sck phase lasts four mclk cycles (80 ns)
module rsd_spi_master
   import rsd_pkg::*;
(
   input wire logic mclk,
   output rsd_pkg::rsd_spi_in_s spi_in,
   input wire logic miso,
   input wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] wbuf [16];
   logic [7:0] rbuf [16];
   wire logic miso_w;

   // bench resolves the three-state wire itself
   assign miso_w = miso_oe ? miso : 1'bz;

   initial begin
      spi_in = '{sck: 1'b0, nss_n: 1'b1, mosi: 1'b0};
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk);
   endtask : wait_n

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_in.mosi = tx[i];
         wait_n(4);
         rx[i] = miso_w;
         spi_in.sck = 1'b1;
         wait_n(4);
         spi_in.sck = 1'b0;
      end
   endtask : xfer

   task automatic frame(input logic [7:0] hdr, input int n);
      logic [7:0] junk;
      wait_n(1);
      spi_in.nss_n = 1'b0;
      wait_n(4);
      xfer(hdr, junk);
      for (int k = 0; k < n; k++) begin
         xfer(wbuf[k], rbuf[k]);
      end
      wait_n(4);
      spi_in.nss_n = 1'b1;
      // idle mosi carries no stale value
      spi_in.mosi = ~spi_in.mosi;
      wait_n(7);
   endtask : frame
endmodule : rsd_spi_master
